// [verif/odr_diag_regs_properties.sv]
`timescale 1ns/1ps
// Port checks of the diagnostic bank
module odr_props #(parameter NUM_STAGES = 18) (
    input wire ref_clk,
    input wire rstn,
    input wire [2*NUM_STAGES-1:0] stage_fault_bits,
    input wire battery_supply_present,
    input wire read_fault_report_cmd,
    input wire [2:0] read_select,
    input wire write_strobe,
    input wire [7:0] read_data
);
    // Short views and read decodes
    wire [2*NUM_STAGES-1:0] f = stage_fault_bits;
    wire b = battery_supply_present;
    wire [7:0] d = read_data;
    wire r0 = read_fault_report_cmd && read_select == 3'h0;
    wire r3 = read_fault_report_cmd && read_select == 3'h3;
    wire r4 = read_fault_report_cmd && read_select == 3'h4;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence q; $stable(f)[*6]; endsequence
    property p_s1; q ##0 r0 && f[1:0] != 2'h3 |=> d[1:0] == $past(f[1:0]); endproperty
    a_s1: assert property (p_s1) else $error("stage 1 field wrong");
    property p_s13; q ##0 r3 && f[25:24] != 2'h3 |=> d[1:0] == $past(f[25:24]); endproperty
    a_s13: assert property (p_s13) else $error("stage 13 field wrong");
    property p_s17; q ##0 r4 && f[33:32] != 2'h3 |=> d[1:0] == $past(f[33:32]); endproperty
    a_s17: assert property (p_s17) else $error("stage 17 field wrong");
    property p_s18; q ##0 r4 && f[35:34] != 2'h3 |=> d[3:2] == $past(f[35:34]); endproperty
    a_s18: assert property (p_s18) else $error("stage 18 field wrong");
    property p_up; b[*6] ##0 r4 |=> d[4]; endproperty
    a_up: assert property (p_up) else $error("supply bit low");
    property p_dn; (!b)[*6] ##0 r4 |=> !d[4]; endproperty
    a_dn: assert property (p_dn) else $error("supply bit high");
    property p_sp; r4 |=> d[7:5] == 3'h7; endproperty
    a_sp: assert property (p_sp) else $error("spare bits not ones");
    property p_wr; write_strobe && !read_fault_report_cmd |=> $stable(d); endproperty
    a_wr: assert property (p_wr) else $error("write changed data");
endmodule // odr_props

// [verif/odr_host.sv]
`timescale 1ns/1ps
// Host side: read, clear and write requests, one edge each
module odr_host (
    input wire ref_clk,
    input wire [7:0] read_data,
    input wire read_valid,
    output reg read_fault_report_cmd,
    output reg [2:0] read_select,
    output reg clear_fault_report_cmd,
    output reg write_strobe,
    output reg [7:0] write_data
);
    initial begin
        read_fault_report_cmd = 1'h0;
        read_select = 3'h0;
        clear_fault_report_cmd = 1'h0;
        write_strobe = 1'h0;
        write_data = 8'h00;
    end
    // Read: answer sampled in the cycle after the request edge
    task rd(input [2:0] s, output [7:0] d, output v);
        @(posedge ref_clk) read_fault_report_cmd <= 1'h1;
        read_select <= s;
        @(posedge ref_clk) read_fault_report_cmd <= 1'h0;
        #1 d = read_data;
        v = read_valid;
    endtask
    // Clear, or a write that is expected to change nothing
    task cw(input c, input [7:0] wd);
        @(posedge ref_clk) clear_fault_report_cmd <= c;
        write_strobe <= !c;
        write_data <= wd;
        @(posedge ref_clk) {clear_fault_report_cmd, write_strobe} <= 2'h0;
    endtask
endmodule // odr_host

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    reg ref_clk = 1'h0;
    reg rstn = 1'h0;
    reg [35:0] stage_fault_bits = {36{1'h1}};
    reg battery_supply_present = 1'h1;
    wire read_fault_report_cmd, clear_fault_report_cmd, write_strobe, read_valid;
    wire [2:0] read_select;
    wire [7:0] write_data, read_data;
    reg [7:0] d;
    reg v;
    integer mismatches = 0, num_checks = 0, i;
    // Clock at 8 ns
    always #4 ref_clk = !ref_clk;
    odr_diag_regs odr_diag_regs_i (.*);
    odr_host odr_host_i (.*);
    task w(input integer n); repeat (n) @(posedge ref_clk); endtask
    task chk(input [7:0] s, input [7:0] e);
        num_checks = num_checks + 1;
        if (s !== e) begin
            mismatches = mismatches + 1;
            $display("FAIL t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task rc(input [2:0] s, input [7:0] e);
        odr_host_i.rd(s, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, e);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task t_reset; for (i = 0; i < 5; i = i + 1) rc(i[2:0], 8'hff); endtask
    // Faults live, then gone but still held
    task t_hold;
        @(posedge ref_clk) stage_fault_bits <= {4'h4, 32'he4e4e4e4};
        w(6);
        repeat (2) begin
            for (i = 0; i < 4; i = i + 1) rc(i[2:0], 8'he4);
            rc(3'h4, 8'hf4);
            @(posedge ref_clk) stage_fault_bits <= {36{1'h1}};
            w(4);
        end
    endtask
    task t_write; odr_host_i.cw(1'h0, 8'h1b); rc(3'h0, 8'he4); endtask
    task t_supply;
        @(posedge ref_clk) battery_supply_present <= 1'h0;
        w(5);
        rc(3'h4, 8'he4);
        @(posedge ref_clk) battery_supply_present <= 1'h1;
        w(5);
        rc(3'h4, 8'hf4);
    endtask
    // Clear with stage 1 still faulty, then with all healthy
    task t_clear;
        @(posedge ref_clk) stage_fault_bits <= {{34{1'h1}}, 2'h0};
        w(6);
        odr_host_i.cw(1'h1, 8'h00);
        rc(3'h0, 8'hfc);
        rc(3'h4, 8'hff);
        rc(3'h7, 8'hff);
        @(posedge ref_clk) stage_fault_bits <= {36{1'h1}};
        w(4);
        odr_host_i.cw(1'h1, 8'h00);
        rc(3'h0, 8'hff);
    endtask
    initial begin
        w(2);
        rstn <= 1'h1;
        w(4);
        t_reset;
        t_hold;
        t_write;
        t_supply;
        t_clear;
        give_verdict;
    end
    // Watchdog well beyond the hundred or so cycles the tests need
    initial begin
        #20000;
        mismatches = mismatches + 1;
        give_verdict;
    end
endmodule // tb_top
bind odr_diag_regs odr_props #(.NUM_STAGES(NUM_STAGES)) odr_props_i (.*);

// [verilog/odr_defs.vh]
`ifndef ODR_DEFS_VH
`define ODR_DEFS_VH
// Register indices (instruction select codes, chosen)
`define ODR_IDX_STAGES_1_TO_4 3'h0
`define ODR_IDX_STAGES_5_TO_8 3'h1
`define ODR_IDX_STAGES_9_TO_12 3'h2
`define ODR_IDX_STAGES_13_TO_16 3'h3
`define ODR_IDX_STAGES_17_18_SUPPLY 3'h4
// Reset values
`define ODR_REG_RESET 8'hff
`define ODR_CODE_RESET 2'h3
// Fault codes, upper bit first
`define ODR_CODE_OK 2'h3
`define ODR_CODE_SCB_OT 2'h2
`define ODR_CODE_OPEN_LOAD 2'h1
`define ODR_CODE_SHORT_GND 2'h0
// Field positions in the fifth register
`define ODR_SUPPLY_BIT 4
`define ODR_SPARE_BITS 3'h7
`endif

// [verilog/odr_diag_regs.v]
`timescale 1ns/1ps
`include "odr_defs.vh"
// Summary of operation
// - Stages 1 to 16 each own a 2-bit field, four per register at bits 1-0, 3-2, 5-4, 7-6.
// - Stage 17 sits at bits 1-0 and stage 18 at bits 3-2 of the fifth register.
// - The registers are read-only; write data aimed at them is ignored.
// - Codes are 11 ok, 10 short to battery or overtemperature, 01 open load, 00 short to ground.
// - Bit 4 of the fifth register reads 1 when battery supply is present, 0 when absent.
// - The supply bit shows the live comparator level and is never latched.
// - Bits 7 to 5 of the fifth register always read 1.
// - A clear command restores all ones except fields whose fault is still present.
//
// Notes on use
// Fault codes pass three flip-flops and the supply level two, so they show three and two clocks late.
// A read command is answered one clock later, with read_valid high for that one clock.
// read_data keeps the last answer until the next read command.
// Select codes 0 to 4 pick the five registers; any other code reads all ones.
// A live fault beats a clear in the same clock, so a stuck fault stays visible.
// The newest non-ok code replaces a held code, so a changing fault shows its latest kind.
// A clear restores ok only to fields whose stage shows no live fault.
// Write strobe and write data reach the block but change nothing.
// The supply bit is the synchronised comparator level, never held.
// It means nothing while the logic supply is low; the host must qualify it.
// Bits 7 to 5 of the fifth register are tied high.
// Only eighteen stages are mapped to registers; NUM_STAGES sizes the inputs.
module odr_diag_regs #(
    parameter NUM_STAGES = 18
) (
    input wire ref_clk,
    input wire rstn,
    input wire [2*NUM_STAGES-1:0] stage_fault_bits,
    input wire battery_supply_present,
    input wire read_fault_report_cmd,
    input wire [2:0] read_select,
    input wire clear_fault_report_cmd,
    input wire write_strobe,
    input wire [7:0] write_data,
    output reg [7:0] read_data,
    output reg read_valid
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation
    wire [2*NUM_STAGES-1:0] fault_sync;
    wire supply_sync;

    // Fault codes from the analogue side idle at ok
    odr_sync2 #(.WIDTH(2*NUM_STAGES), .INIT({NUM_STAGES{`ODR_CODE_RESET}})) u_fault_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(stage_fault_bits),
        .sync_out(fault_sync)
    );

    // Comparator level for supply presence
    odr_sync2 #(.WIDTH(1), .INIT(1'b0)) u_supply_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(battery_supply_present),
        .sync_out(supply_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Live fault flags
    reg [NUM_STAGES-1:0] live_fault;
    integer k;

    // True when a stage code is anything but ok
    function odr_is_fault;
        input [1:0] code;
        begin
            odr_is_fault = (code != `ODR_CODE_OK);
        end
    endfunction

    // One flag per stage, taken after the synchroniser
    always @* begin
        live_fault = {NUM_STAGES{1'b0}};
        for (k = 0; k < NUM_STAGES; k = k + 1) begin
            live_fault[k] = odr_is_fault(fault_sync[2*k +: 2]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clear qualification
    reg [NUM_STAGES-1:0] restore_field;
    integer m;

    // A field goes back to ok only while its stage shows no live fault
    always @* begin
        restore_field = {NUM_STAGES{1'b0}};
        for (m = 0; m < NUM_STAGES; m = m + 1) begin
            restore_field[m] = clear_fault_report_cmd && !live_fault[m];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault capture
    reg [2*NUM_STAGES-1:0] held;
    reg [2*NUM_STAGES-1:0] next_held;
    integer i;

    // Newest fault code wins, a restore brings back ok, otherwise hold
    function [1:0] odr_capture;
        input [1:0] cur;
        input [1:0] live;
        input fault;
        input restore;
        begin
            if (fault)
                odr_capture = live;
            else if (restore)
                odr_capture = `ODR_CODE_OK;
            else
                odr_capture = cur;
        end
    endfunction

    // Live fault wins over clear in the same cycle
    always @* begin
        next_held = held;
        for (i = 0; i < NUM_STAGES; i = i + 1) begin
            next_held[2*i +: 2] = odr_capture(held[2*i +: 2], fault_sync[2*i +: 2],
                live_fault[i], restore_field[i]);
        end
    end

    // Write strobe and data play no part in the fields
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            held <= {NUM_STAGES{`ODR_CODE_RESET}};
        end else begin
            held <= next_held;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register views
    wire [7:0] view_stages_1_to_4;
    wire [7:0] view_stages_5_to_8;
    wire [7:0] view_stages_9_to_12;
    wire [7:0] view_stages_13_to_16;
    wire [7:0] view_stages_17_18_supply;

    // Four stage fields per byte, lowest stage in bits 1-0
    function [7:0] odr_stage_byte;
        input [2*NUM_STAGES-1:0] fields;
        input integer first;
        begin
            odr_stage_byte = fields[2*first +: 8];
        end
    endfunction

    // Fifth byte: spare ones, supply level, stages 18 and 17
    function [7:0] odr_supply_byte;
        input [3:0] pair;
        input supply;
        begin
            odr_supply_byte = {`ODR_SPARE_BITS, supply, pair};
        end
    endfunction

    // Views of the held fields, in select order
    assign view_stages_1_to_4 = odr_stage_byte(held, 0);
    assign view_stages_5_to_8 = odr_stage_byte(held, 4);
    assign view_stages_9_to_12 = odr_stage_byte(held, 8);
    assign view_stages_13_to_16 = odr_stage_byte(held, 12);
    assign view_stages_17_18_supply = odr_supply_byte(held[35:32], supply_sync);

    ////////////////////////////////////////////////////////////////////////
    // Select decode
    reg [4:0] select_hot;

    // One-hot pick of the five registers; any other code picks none
    function [4:0] odr_decode_select;
        input [2:0] sel;
        begin
            case (sel)
                `ODR_IDX_STAGES_1_TO_4: odr_decode_select = 5'h01;
                `ODR_IDX_STAGES_5_TO_8: odr_decode_select = 5'h02;
                `ODR_IDX_STAGES_9_TO_12: odr_decode_select = 5'h04;
                `ODR_IDX_STAGES_13_TO_16: odr_decode_select = 5'h08;
                `ODR_IDX_STAGES_17_18_SUPPLY: odr_decode_select = 5'h10;
                default: odr_decode_select = 5'h00;
            endcase
        end
    endfunction

    // Decoded select for the read mux
    always @* begin
        select_hot = odr_decode_select(read_select);
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path
    reg [7:0] next_read;

    // Register select; unknown codes read all ones
    always @* begin
        case (select_hot)
            5'h01: next_read = view_stages_1_to_4;
            5'h02: next_read = view_stages_5_to_8;
            5'h04: next_read = view_stages_9_to_12;
            5'h08: next_read = view_stages_13_to_16;
            5'h10: next_read = view_stages_17_18_supply;
            default: next_read = `ODR_REG_RESET;
        endcase
    end

    // Answer one cycle after the read command; data holds until the next read
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            read_data <= `ODR_REG_RESET;
            read_valid <= 1'b0;
        end else begin
            read_valid <= read_fault_report_cmd;
            if (read_fault_report_cmd) begin
                read_data <= next_read;
            end
        end
    end
endmodule // odr_diag_regs

// [verilog/odr_sync2.v]
`timescale 1ns/1ps
// Two flip-flop synchroniser for a bus of levels
module odr_sync2 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire ref_clk,
    input wire rstn,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta;

    // First stage read only by the second
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta <= INIT;
            sync_out <= INIT;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // odr_sync2
